// ---- inc/ebwc_cfg.svh ----
// Register offsets, field positions, reset values and AXI responses for the wait-state controller
`ifndef EBWC_CFG_SVH
`define EBWC_CFG_SVH

// Register indices; byte address is four times the index
`define EBWC_IDX_ACCESS_STATE 8'hED
`define EBWC_IDX_WAIT_SETUP 8'hEE
`define EBWC_IDX_WAIT_ENABLE 8'hEF

// Reset values
`define EBWC_RST_ACCESS_STATE 8'hFF
`define EBWC_RST_WAIT_SETUP 8'hF3
`define EBWC_RST_WAIT_ENABLE 8'hFF
`define EBWC_SETUP_RSVD 4'hF

// Wait setup fields
`define EBWC_MODE_HI 3
`define EBWC_MODE_LO 2
`define EBWC_COUNT_HI 1
`define EBWC_COUNT_LO 0

// Area select bits per address mode
`define EBWC_AREA_LSB_1M 17
`define EBWC_AREA_LSB_16M 21

// AXI responses
`define EBWC_RESP_OKAY 2'b00
`define EBWC_RESP_SLVERR 2'b10

`endif

// ---- inc/ebwc_pkg.sv ----
// Types of the external bus wait-state controller
package ebwc_pkg;

    typedef enum logic [1:0] {
        EBWC_MODE_PROG,
        EBWC_MODE_NONE,
        EBWC_MODE_PIN1,
        EBWC_MODE_AUTO
    } ebwc_wait_mode_t;

    typedef enum logic [2:0] {
        EBWC_S_IDLE,
        EBWC_S_T1,
        EBWC_S_T2,
        EBWC_S_TW,
        EBWC_S_T3
    } ebwc_state_t;

    typedef struct packed {
        logic internal;
        logic write;
        logic three_state;
        logic wait_en;
        ebwc_wait_mode_t mode;
        logic [1:0] count;
    } ebwc_cycle_cfg_t;

endpackage

// ---- rtl/ebwc_top.sv ----
// External bus access-state and wait-state controller with AXI4-Lite registers
//
// Contract
// - Area access bit 0 gives two-state access, 1 gives three-state access.
// - On-chip accesses take fixed states, ignoring all area settings.
// - Wait-enable bit 0 selects pin wait mode 0; 1 enables controller.
// - Wait-enable register resets to all ones on reset and hardware standby.
// - Areas 0..7 span 128 kbytes (1-Mbyte mode) or 2 Mbytes (16-Mbyte).
// - Access and enable bits are per area; wait mode is shared.
// - Mode 00 programmable, 01 none, 10 pin mode 1, 11 auto.
// - Two-state accesses never get wait states.
// - Pin mode 0: low wait pin in T2 adds waits until high.
// - Pin mode 1: programmed waits, then pin sampled in last wait.
// - Pin mode 1 with zero count behaves as pin mode 0.
// - Auto mode: low pin in T2 inserts exactly the count, nothing more.
// - Programmable mode inserts the count and ignores the pin.
// - After reset all areas three-state, enabled, programmable, three waits.
// - Access and enable writes take effect from the next bus cycle.
// - Count field 00..11 selects 0..3 waits, reset value 3.
// - Drive address strobe, read strobe and write strobe with data.
`include "ebwc_cfg.svh"

module ebwc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic HW_STANDBY,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic MODE_16M,
    input wire logic REQ,
    input wire logic REQ_INTERNAL,
    input wire logic REQ_WRITE,
    input wire logic [23:0] REQ_ADDR,
    input wire logic [7:0] REQ_WDATA,
    output logic BUS_IDLE,
    output logic DONE,
    output logic [7:0] RDATA,
    output logic [23:0] EXT_ADDR,
    output logic [7:0] EXT_DATA_OUT,
    output logic EXT_DATA_OE,
    input wire logic [7:0] EXT_DATA_IN,
    output logic ADDRESS_STROBE_N,
    output logic READ_STROBE_N,
    output logic WRITE_STROBE_N,
    input wire logic WAIT_REQ_N
);

    if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must be 10 to 32");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] area_access_state_reg_q;
    logic [3:0] wait_setup_reg_q;
    logic [7:0] area_wait_controller_enable_q;

    logic aw_idle_q, w_idle_q, bvalid_q, ar_idle_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;

    wire aw_fire = S_AXI_AWVALID && aw_idle_q;
    wire w_fire = S_AXI_WVALID && w_idle_q;
    wire wr_do = !aw_idle_q && !w_idle_q && !bvalid_q;
    wire ar_fire = S_AXI_ARVALID && ar_idle_q;
    wire [ADDR_W-3:0] wr_word = aw_addr_q[ADDR_W-1:2];
    wire [ADDR_W-3:0] rd_word = S_AXI_ARADDR[ADDR_W-1:2];
    wire wr_hit_as = wr_word == (ADDR_W-2)'(`EBWC_IDX_ACCESS_STATE);
    wire wr_hit_ws = wr_word == (ADDR_W-2)'(`EBWC_IDX_WAIT_SETUP);
    wire wr_hit_we = wr_word == (ADDR_W-2)'(`EBWC_IDX_WAIT_ENABLE);
    wire wr_hit = wr_hit_as || wr_hit_ws || wr_hit_we;
    wire wr_en = wr_do && w_lane0_q;
    wire rd_hit_as = rd_word == (ADDR_W-2)'(`EBWC_IDX_ACCESS_STATE);
    wire rd_hit_ws = rd_word == (ADDR_W-2)'(`EBWC_IDX_WAIT_SETUP);
    wire rd_hit_we = rd_word == (ADDR_W-2)'(`EBWC_IDX_WAIT_ENABLE);
    wire rd_hit = rd_hit_as || rd_hit_ws || rd_hit_we;
    wire [7:0] rd_byte = rd_hit_as ? area_access_state_reg_q :
                         rd_hit_ws ? {`EBWC_SETUP_RSVD, wait_setup_reg_q} :
                         rd_hit_we ? area_wait_controller_enable_q : 8'h00;
    wire cfg_rst = RST || HW_STANDBY;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            aw_idle_q <= 1'b1;
            w_idle_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `EBWC_RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_idle_q <= 1'b0;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (w_fire) begin
                w_idle_q <= 1'b0;
                w_data_q <= S_AXI_WDATA[7:0];
                w_lane0_q <= S_AXI_WSTRB[0];
            end
            if (wr_do) begin
                aw_idle_q <= 1'b1;
                w_idle_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `EBWC_RESP_OKAY : `EBWC_RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ar_idle_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `EBWC_RESP_OKAY;
        end else if (ar_fire) begin
            ar_idle_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_hit ? `EBWC_RESP_OKAY : `EBWC_RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            ar_idle_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // Configuration survives software standby; only reset and hardware standby clear it
    always_ff @(posedge CLOCK) begin
        if (cfg_rst) begin
            area_access_state_reg_q <= `EBWC_RST_ACCESS_STATE;
            wait_setup_reg_q <= 4'(`EBWC_RST_WAIT_SETUP & 8'h0F);
            area_wait_controller_enable_q <= `EBWC_RST_WAIT_ENABLE;
        end else if (wr_en) begin
            if (wr_hit_as) area_access_state_reg_q <= w_data_q;
            if (wr_hit_ws) wait_setup_reg_q <= w_data_q[3:0];
            if (wr_hit_we) area_wait_controller_enable_q <= w_data_q;
        end
    end

    assign S_AXI_AWREADY = aw_idle_q;
    assign S_AXI_WREADY = w_idle_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = ar_idle_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic wait_n_meta_q, wait_n_sync_q;
    logic [7:0] din_meta_q, din_sync_q;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wait_n_meta_q <= 1'b1;
            wait_n_sync_q <= 1'b1;
            din_meta_q <= 8'h00;
            din_sync_q <= 8'h00;
        end else begin
            wait_n_meta_q <= WAIT_REQ_N;
            wait_n_sync_q <= wait_n_meta_q;
            din_meta_q <= EXT_DATA_IN;
            din_sync_q <= din_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    ebwc_pkg::ebwc_state_t state_q, state_d;
    ebwc_pkg::ebwc_cycle_cfg_t cur_q, new_cfg;
    logic [1:0] cnt_q, cnt_d;
    logic pin_q, pin_d;
    logic done_q;

    wire start = REQ && state_q == ebwc_pkg::EBWC_S_IDLE;
    wire [2:0] area = MODE_16M ? REQ_ADDR[`EBWC_AREA_LSB_16M +: 3] :
                                 REQ_ADDR[`EBWC_AREA_LSB_1M +: 3];
    wire wait_low = !wait_n_sync_q;

    // Per-area bits plus the shared mode, frozen at T1 of each cycle
    assign new_cfg.internal = REQ_INTERNAL;
    assign new_cfg.write = REQ_WRITE;
    assign new_cfg.three_state = !REQ_INTERNAL && area_access_state_reg_q[area];
    assign new_cfg.wait_en = area_wait_controller_enable_q[area];
    assign new_cfg.mode = ebwc_pkg::ebwc_wait_mode_t'(
        wait_setup_reg_q[`EBWC_MODE_HI:`EBWC_MODE_LO]);
    assign new_cfg.count = wait_setup_reg_q[`EBWC_COUNT_HI:`EBWC_COUNT_LO];

    // Decision taken in T2 of a three-state cycle
    wire cnt_zero = cur_q.count == 2'd0;
    wire pin0 = !cur_q.wait_en ||
        (cur_q.mode == ebwc_pkg::EBWC_MODE_PIN1 && cnt_zero);
    wire prog = cur_q.wait_en && cur_q.mode == ebwc_pkg::EBWC_MODE_PROG;
    wire pin1 = cur_q.wait_en && cur_q.mode == ebwc_pkg::EBWC_MODE_PIN1;
    wire autow = cur_q.wait_en && cur_q.mode == ebwc_pkg::EBWC_MODE_AUTO;
    wire t2_wait = pin0 ? wait_low :
                   prog ? !cnt_zero :
                   pin1 ? 1'b1 :
                   autow ? wait_low && !cnt_zero : 1'b0;
    wire [1:0] t2_cnt = pin0 ? 2'd0 : cur_q.count;
    wire t2_pin = pin0 || pin1;
    // Stay in wait while programmed waits remain or pin holds the last one
    wire tw_stay = cnt_q > 2'd1 || (pin_q && wait_low);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pin_d = pin_q;
        unique case (state_q)
            ebwc_pkg::EBWC_S_IDLE: begin
                if (start) state_d = ebwc_pkg::EBWC_S_T1;
            end
            ebwc_pkg::EBWC_S_T1: state_d = ebwc_pkg::EBWC_S_T2;
            ebwc_pkg::EBWC_S_T2: begin
                if (!cur_q.three_state) begin
                    state_d = ebwc_pkg::EBWC_S_IDLE;
                end else if (t2_wait) begin
                    state_d = ebwc_pkg::EBWC_S_TW;
                    cnt_d = t2_cnt;
                    pin_d = t2_pin;
                end else begin
                    state_d = ebwc_pkg::EBWC_S_T3;
                end
            end
            ebwc_pkg::EBWC_S_TW: begin
                if (cnt_q != 2'd0) cnt_d = cnt_q - 2'd1;
                if (!tw_stay) state_d = ebwc_pkg::EBWC_S_T3;
            end
            ebwc_pkg::EBWC_S_T3: state_d = ebwc_pkg::EBWC_S_IDLE;
        endcase
    end

    wire cur_d_internal = start ? REQ_INTERNAL : cur_q.internal;
    wire ext_d = !cur_d_internal && state_d != ebwc_pkg::EBWC_S_IDLE;
    wire cur_d_write = start ? REQ_WRITE : cur_q.write;
    wire strobe2_d = state_d == ebwc_pkg::EBWC_S_T2 || state_d == ebwc_pkg::EBWC_S_TW ||
                     state_d == ebwc_pkg::EBWC_S_T3;
    wire finish = state_q != ebwc_pkg::EBWC_S_IDLE && state_d == ebwc_pkg::EBWC_S_IDLE;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= ebwc_pkg::EBWC_S_IDLE;
            cur_q <= '0;
            cnt_q <= 2'd0;
            pin_q <= 1'b0;
            BUS_IDLE <= 1'b1;
            DONE <= 1'b0;
            done_q <= 1'b0;
            RDATA <= 8'h00;
            EXT_ADDR <= 24'h00_0000;
            EXT_DATA_OUT <= 8'h00;
            EXT_DATA_OE <= 1'b0;
            ADDRESS_STROBE_N <= 1'b1;
            READ_STROBE_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d;
            BUS_IDLE <= state_d == ebwc_pkg::EBWC_S_IDLE;
            // Data pins lag two edges, so DONE and read capture trail the last state
            done_q <= finish;
            DONE <= done_q;
            if (start) begin
                cur_q <= new_cfg;
                EXT_ADDR <= REQ_ADDR;
                EXT_DATA_OUT <= REQ_WDATA;
            end
            if (done_q && !cur_q.write) RDATA <= din_sync_q;
            ADDRESS_STROBE_N <= !ext_d;
            READ_STROBE_N <= !(ext_d && !cur_d_write);
            WRITE_STROBE_N <= !(ext_d && cur_d_write && strobe2_d);
            EXT_DATA_OE <= ext_d && cur_d_write;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_two_state;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_T2 && !cur_q.three_state) |=>
            state_q == ebwc_pkg::EBWC_S_IDLE ##1 DONE;
    endproperty
    a_two_state: assert property (p_two_state) else $error("two-state cycle overran T2");

    property p_three_state;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_T2 && cur_q.three_state) |=>
            state_q inside {ebwc_pkg::EBWC_S_TW, ebwc_pkg::EBWC_S_T3};
    endproperty
    a_three_state: assert property (p_three_state) else $error("three-state cycle lost T3");

    property p_prog_two;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_T2 && cur_q.three_state && prog && cur_q.count == 2'd2)
            |=> state_q == ebwc_pkg::EBWC_S_TW [*2] ##1 state_q == ebwc_pkg::EBWC_S_T3;
    endproperty
    a_prog_two: assert property (p_prog_two) else $error("programmed wait count wrong");

    property p_auto_high;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_T2 && cur_q.three_state && autow && !wait_low)
            |=> state_q == ebwc_pkg::EBWC_S_T3;
    endproperty
    a_auto_high: assert property (p_auto_high) else $error("auto wait without pin");

    property p_auto_last;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_TW && autow && cnt_q <= 2'd1) |=>
            state_q == ebwc_pkg::EBWC_S_T3;
    endproperty
    a_auto_last: assert property (p_auto_last) else $error("auto wait extended");

    property p_pin0;
        @(posedge CLOCK) disable iff (RST)
        (state_q == ebwc_pkg::EBWC_S_T2 && cur_q.three_state && pin0 && wait_low)
            |=> state_q == ebwc_pkg::EBWC_S_TW;
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin wait 0 missed wait");

    property p_standby;
        @(posedge CLOCK) disable iff (RST)
        HW_STANDBY |=> area_wait_controller_enable_q == 8'hFF &&
            area_access_state_reg_q == 8'hFF && wait_setup_reg_q == 4'h3;
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not restore setup");

    property p_frozen;
        @(posedge CLOCK) disable iff (RST)
        (state_q != ebwc_pkg::EBWC_S_IDLE && $past(state_q) != ebwc_pkg::EBWC_S_IDLE)
            |-> $stable(cur_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("cycle setup changed mid-cycle");

    property p_internal;
        @(posedge CLOCK) disable iff (RST)
        (state_q != ebwc_pkg::EBWC_S_IDLE && cur_q.internal) |->
            ADDRESS_STROBE_N && READ_STROBE_N && WRITE_STROBE_N;
    endproperty
    a_internal: assert property (p_internal) else $error("strobe on internal access");

    property p_write_strobe;
        @(posedge CLOCK) disable iff (RST)
        !WRITE_STROBE_N |-> cur_q.write && EXT_DATA_OE && !ADDRESS_STROBE_N;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe misplaced");

    c_pin1_ext: cover property (@(posedge CLOCK) disable iff (RST)
        state_q == ebwc_pkg::EBWC_S_TW && pin1 && cnt_q == 2'd0);
    c_auto_wait: cover property (@(posedge CLOCK) disable iff (RST)
        state_q == ebwc_pkg::EBWC_S_TW && autow);
    c_two_write: cover property (@(posedge CLOCK) disable iff (RST)
        state_q == ebwc_pkg::EBWC_S_T2 && !cur_q.three_state && cur_q.write);
    c_axi_write: cover property (@(posedge CLOCK) disable iff (RST) wr_en && wr_hit_as);

endmodule // ebwc_top

// ---- verif/ebwc_ext_mem.sv ----
// Behavioural external byte memory with a wait request output
module ebwc_ext_mem (
    input wire logic clock,
    input wire logic [23:0] ext_addr,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_oe,
    output logic [7:0] ext_data_in,
    input wire logic address_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    output logic wait_req_n,
    input wire logic stall_go,
    input wire logic [4:0] stall_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [256];
    logic [7:0] last_q;
    logic [4:0] stall_q;

    initial begin
        foreach (mem_q[i]) mem_q[i] = 8'h00;
        last_q = 8'h00;
        stall_q = 5'h00;
    end

    // Store only while the write strobe and the data drive are both on
    always @(posedge clock) begin
        if (!write_strobe_n && ext_data_oe) mem_q[ext_addr[7:0]] <= ext_data_out;
        if (!read_strobe_n && !address_strobe_n) last_q <= mem_q[ext_addr[7:0]];
        stall_q <= stall_go ? stall_len : (stall_q != 5'h00 ? stall_q - 5'h01 : 5'h00);
    end

    // Released data lines show the inverse of the last byte
    assign ext_data_in = !read_strobe_n ? mem_q[ext_addr[7:0]] : ~last_q;
    // Wait request held low while the stall count runs
    assign wait_req_n = (stall_q == 5'h00);
endmodule // ebwc_ext_mem

// ---- verif/testbench.sv ----
// Self-checking bench for the external bus wait-state controller
`include "ebwc_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Signals and instances
    // ----
    localparam logic [11:0] A_AST = 12'(`EBWC_IDX_ACCESS_STATE) << 2;
    localparam logic [11:0] A_WCR = 12'(`EBWC_IDX_WAIT_SETUP) << 2;
    localparam logic [11:0] A_WCE = 12'(`EBWC_IDX_WAIT_ENABLE) << 2;
    logic CLOCK, RST, HW_STANDBY, MODE_16M, stall_go;
    logic S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
    logic REQ, REQ_INTERNAL, REQ_WRITE, BUS_IDLE, DONE, EXT_DATA_OE;
    logic [23:0] REQ_ADDR, EXT_ADDR;
    logic [7:0] REQ_WDATA, RDATA, EXT_DATA_OUT, EXT_DATA_IN;
    logic ADDRESS_STROBE_N, READ_STROBE_N, WRITE_STROBE_N, WAIT_REQ_N;
    logic [4:0] stall_len;
    int error_cnt, n_tests, lat, m, p, want;

    ebwc_top #(.ADDR_W(12)) ebwc_top_i (
        .CLOCK(CLOCK), .RST(RST), .HW_STANDBY(HW_STANDBY),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hF),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .MODE_16M(MODE_16M), .REQ(REQ), .REQ_INTERNAL(REQ_INTERNAL), .REQ_WRITE(REQ_WRITE),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .BUS_IDLE(BUS_IDLE), .DONE(DONE),
        .RDATA(RDATA), .EXT_ADDR(EXT_ADDR), .EXT_DATA_OUT(EXT_DATA_OUT),
        .EXT_DATA_OE(EXT_DATA_OE), .EXT_DATA_IN(EXT_DATA_IN),
        .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
        .WRITE_STROBE_N(WRITE_STROBE_N), .WAIT_REQ_N(WAIT_REQ_N));

    ebwc_ext_mem ebwc_ext_mem_i (
        .clock(CLOCK), .ext_addr(EXT_ADDR), .ext_data_out(EXT_DATA_OUT),
        .ext_data_oe(EXT_DATA_OE), .ext_data_in(EXT_DATA_IN),
        .address_strobe_n(ADDRESS_STROBE_N), .read_strobe_n(READ_STROBE_N),
        .write_strobe_n(WRITE_STROBE_N), .wait_req_n(WAIT_REQ_N),
        .stall_go(stall_go), .stall_len(stall_len));

    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        error_cnt++;
        $display("[ERR] %s expected completion seen timeout", what);
        tally_and_finish();
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n = 0;
        bit av = 1;
        bit wv = 1;
        @(posedge CLOCK);
        S_AXI_AWVALID <= 1'b1;
        S_AXI_AWADDR <= a;
        S_AXI_WVALID <= 1'b1;
        S_AXI_WDATA <= {24'h00_0000, d};
        S_AXI_BREADY <= 1'b1;
        forever begin
            @(posedge CLOCK);
            n++;
            if (n > 50) hang("axi write");
            if (av && S_AXI_AWREADY === 1'b1) begin
                av = 0;
                S_AXI_AWVALID <= 1'b0;
            end
            if (wv && S_AXI_WREADY === 1'b1) begin
                wv = 0;
                S_AXI_WVALID <= 1'b0;
            end
            if (S_AXI_BVALID === 1'b1) break;
        end
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        bit av = 1;
        @(posedge CLOCK);
        S_AXI_ARVALID <= 1'b1;
        S_AXI_ARADDR <= a;
        S_AXI_RREADY <= 1'b1;
        forever begin
            @(posedge CLOCK);
            n++;
            if (n > 50) hang("axi read");
            if (av && S_AXI_ARREADY === 1'b1) begin
                av = 0;
                S_AXI_ARVALID <= 1'b0;
            end
            if (S_AXI_RVALID === 1'b1) break;
        end
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask

    // Pin low for len cycles, starting before the next request
    task automatic stall(input logic [4:0] len);
        @(posedge CLOCK);
        stall_go <= 1'b1;
        stall_len <= len;
        @(posedge CLOCK);
        stall_go <= 1'b0;
    endtask

    // Returns edges from the take edge to the end of the last state
    task automatic bus_cyc(input logic il, input logic wr, input logic [23:0] a,
                           input logic [7:0] d, output int l);
        @(posedge CLOCK);
        REQ <= 1'b1;
        REQ_INTERNAL <= il;
        REQ_WRITE <= wr;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        @(posedge CLOCK);
        REQ <= 1'b0;
        l = 0;
        do begin
            @(posedge CLOCK);
            l++;
            if (l > 40) hang("bus cycle");
        end while (DONE !== 1'b1);
        l = l - 2;
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    initial begin
        RST = 1'b1;
        HW_STANDBY = 1'b0;
        MODE_16M = 1'b0;
        stall_go = 1'b0;
        stall_len = 5'h00;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        S_AXI_AWADDR = 12'h000;
        S_AXI_ARADDR = 12'h000;
        S_AXI_WDATA = 32'h0000_0000;
        {REQ, REQ_INTERNAL, REQ_WRITE} = 3'h0;
        REQ_ADDR = 24'h00_0000;
        REQ_WDATA = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        axi_rd(A_AST, rd, resp);
        chk("access reset", rd, 32'h0000_00FF);
        axi_rd(A_WCR, rd, resp);
        chk("setup reset", rd, 32'h0000_00F3);
        axi_rd(A_WCE, rd, resp);
        chk("enable reset", rd, 32'h0000_00FF);
        axi_rd(12'h3C0, rd, resp);
        chk("unmapped read resp", 32'(resp), 32'h0000_0002);
        axi_wr(12'h3C0, 8'h00, resp);
        chk("unmapped write resp", 32'(resp), 32'h0000_0002);
        bus_cyc(1'b0, 1'b0, 24'h00_0010, 8'h00, lat);
        chk("reset cycle length", 32'(lat), 32'h0000_0006);
        chk("address out", 32'(EXT_ADDR), 32'h0000_0010);
        chk("idle after cycle", 32'(BUS_IDLE), 32'h0000_0001);
        $display("test reset values done");
        for (m = 0; m < 4; m++) begin
            axi_wr(A_WCR, 8'(m * 4 + 2), resp);
            for (p = 0; p < 2; p++) begin
                stall(p ? 5'h08 : 5'h00);
                bus_cyc(1'b0, 1'b0, 24'h00_0020, 8'h00, lat);
                want = (m == 1 || (m == 3 && p == 0)) ? 3 : 5;
                if (m == 2 && p == 1) chk("pin mode 1 extra", 32'(lat > 5), 32'h1);
                else chk("mode length", 32'(lat), 32'(want));
            end
        end
        axi_rd(A_WCR, rd, resp);
        chk("setup readback", rd, 32'h0000_00FE);
        $display("test wait modes done");
        axi_wr(A_WCE, 8'hFE, resp);
        chk("mapped write resp", 32'(resp), 32'h0000_0000);
        for (p = 0; p < 2; p++) begin
            stall(p ? 5'h08 : 5'h00);
            bus_cyc(1'b0, 1'b0, 24'h00_0030, 8'h00, lat);
            chk("pin mode 0 stretch", 32'(lat > 3), 32'(p));
        end
        stall(5'h08);
        bus_cyc(1'b0, 1'b0, 24'h02_0000, 8'h00, lat);
        chk("area 1 auto length", 32'(lat), 32'h0000_0005);
        axi_wr(A_WCE, 8'hFF, resp);
        axi_wr(A_WCR, 8'h08, resp);
        for (p = 0; p < 2; p++) begin
            stall(p ? 5'h08 : 5'h00);
            bus_cyc(1'b0, 1'b0, 24'h00_0040, 8'h00, lat);
            chk("pin mode 1 zero count", 32'(lat > 3), 32'(p));
        end
        $display("test pin modes done");
        axi_wr(A_AST, 8'hEF, resp);
        stall(5'h08);
        bus_cyc(1'b0, 1'b0, 24'h08_0000, 8'h00, lat);
        chk("two-state length", 32'(lat), 32'h0000_0002);
        axi_wr(A_WCR, 8'h01, resp);
        @(posedge CLOCK);
        MODE_16M <= 1'b1;
        bus_cyc(1'b0, 1'b0, 24'h08_0000, 8'h00, lat);
        chk("16M area 0 length", 32'(lat), 32'h0000_0004);
        bus_cyc(1'b0, 1'b0, 24'h80_0000, 8'h00, lat);
        chk("16M area 4 length", 32'(lat), 32'h0000_0002);
        bus_cyc(1'b1, 1'b0, 24'h00_0000, 8'h00, lat);
        chk("internal length", 32'(lat), 32'h0000_0002);
        bus_cyc(1'b0, 1'b1, 24'h80_0005, 8'h5A, lat);
        bus_cyc(1'b0, 1'b1, 24'h00_0006, 8'hA5, lat);
        bus_cyc(1'b0, 1'b0, 24'h80_0005, 8'h00, lat);
        chk("two-state read data", 32'(RDATA), 32'h0000_005A);
        bus_cyc(1'b0, 1'b0, 24'h00_0006, 8'h00, lat);
        chk("three-state read data", 32'(RDATA), 32'h0000_00A5);
        $display("test areas and data done");
        fork
            bus_cyc(1'b0, 1'b0, 24'h00_0007, 8'h00, lat);
            axi_wr(A_AST, 8'hEE, resp);
        join
        chk("cycle during write", 32'(lat), 32'h0000_0004);
        bus_cyc(1'b0, 1'b0, 24'h00_0007, 8'h00, lat);
        chk("cycle after write", 32'(lat), 32'h0000_0002);
        axi_wr(A_WCE, 8'h00, resp);
        axi_rd(A_WCE, rd, resp);
        chk("enable cleared", rd, 32'h0000_0000);
        @(posedge CLOCK);
        HW_STANDBY <= 1'b1;
        @(posedge CLOCK);
        HW_STANDBY <= 1'b0;
        axi_rd(A_WCE, rd, resp);
        chk("enable after standby", rd, 32'h0000_00FF);
        $display("test write timing and standby done");
        tally_and_finish();
    end
endmodule // testbench
